// [inc/vpic_pkg.sv]
package vpic_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_SRC = 32;
    localparam int PRIO_W = 3;
    localparam int STACK_DEPTH = 8;
    localparam int SRC_W = 5;
    localparam int ADDR_W = 12;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] SMR_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] SVR_BASE = 12'h080;
    localparam logic [ADDR_W-1:0] IVR_OFF = 12'h100;
    localparam logic [ADDR_W-1:0] FVR_OFF = 12'h104;
    localparam logic [ADDR_W-1:0] ISR_OFF = 12'h108;
    localparam logic [ADDR_W-1:0] IPR_OFF = 12'h10C;
    localparam logic [ADDR_W-1:0] IMR_OFF = 12'h110;
    localparam logic [ADDR_W-1:0] CISR_OFF = 12'h114;
    localparam logic [ADDR_W-1:0] IECR_OFF = 12'h120;
    localparam logic [ADDR_W-1:0] IDCR_OFF = 12'h124;
    localparam logic [ADDR_W-1:0] ICCR_OFF = 12'h128;
    localparam logic [ADDR_W-1:0] ISCR_OFF = 12'h12C;
    localparam logic [ADDR_W-1:0] EOICR_OFF = 12'h130;
    localparam logic [ADDR_W-1:0] SPU_OFF = 12'h134;
    localparam logic [ADDR_W-1:0] DCR_OFF = 12'h138;
    localparam logic [ADDR_W-1:0] FFER_OFF = 12'h140;
    localparam logic [ADDR_W-1:0] FFDR_OFF = 12'h144;
    localparam logic [ADDR_W-1:0] FFSR_OFF = 12'h148;
    localparam logic [ADDR_W-1:0] BANK_MASK = 12'hF80;
    // ------------------------------------------------------------
    // Source mode field layout
    // ------------------------------------------------------------
    localparam int PRIO_LSB = 0;
    localparam int TRIG_LSB = 5;
    localparam int DCR_GMSK_BIT = 1;
    // Trigger type: 00 level low/int level, 01 edge fall/int edge,
    // 10 level high, 11 edge rise
    localparam logic [1:0] TRIG_LVL_LOW = 2'h0;
    localparam logic [1:0] TRIG_EDGE_NEG = 2'h1;
    localparam logic [1:0] TRIG_LVL_HIGH = 2'h2;
    localparam logic [1:0] TRIG_EDGE_POS = 2'h3;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [SRC_W-1:0] FAST_SRC = 5'h00;

    typedef struct packed {
        logic [1:0] trigger_type_field;
        logic [PRIO_W-1:0] priority_level_field;
    } vpic_mode_s;

    typedef struct packed {
        logic [SRC_W-1:0] num;
        logic [PRIO_W-1:0] lvl;
    } vpic_frame_s;
endpackage

// [hdl/vpic_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module vpic_ctrl #(
    parameter int NUM_EXT = 2,
    parameter logic [31:0] EXT_SRC_MAP = 32'hC000_0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [vpic_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fast_int_pin,
    input wire logic [vpic_pkg::NUM_SRC-1:0] periph_int,
    input wire logic [NUM_EXT-1:0] ext_int_pins,
    output logic normal_int_request_n,
    output logic fast_int_request_n,
    output logic core_wake
);
    import vpic_pkg::*;

    // Elaboration-time refusal of pin counts the source map cannot serve
    if (NUM_EXT < 1 || NUM_EXT > NUM_SRC - 2) begin : g_bad_ext
        $error("NUM_EXT out of range");
    end
    if ($countones(EXT_SRC_MAP[NUM_SRC-1:2]) < NUM_EXT) begin : g_bad_map
        $error("EXT_SRC_MAP has too few pin slots");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic is_edge(input logic [1:0] t);
        return t[0];
    endfunction

    function automatic logic [SRC_W-1:0] src_idx(input int i);
        return SRC_W'(i);
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers and source assembly
    // ------------------------------------------------------------
    logic [NUM_EXT:0] sync1_ff;
    logic [NUM_EXT:0] sync2_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {ext_int_pins, fast_int_pin};
            sync2_ff <= sync1_ff;
        end
    end

    // Raw source levels; the shared peripheral line already arrives ORed
    logic [NUM_SRC-1:0] src_raw;
    logic [NUM_SRC-1:0] ext_mask;
    always_comb begin
        int k;
        k = 1;
        src_raw = periph_int;
        ext_mask = '0;
        src_raw[0] = sync2_ff[0];
        ext_mask[0] = 1'b1;
        for (int i = 2; i < NUM_SRC; i++) begin
            if (EXT_SRC_MAP[i] && k <= NUM_EXT) begin
                src_raw[i] = sync2_ff[k];
                ext_mask[i] = 1'b1;
                k = k + 1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    vpic_mode_s mode_ff [NUM_SRC];
    logic [31:0] svr_ff [NUM_SRC];
    logic [31:0] spu_ff;
    logic [NUM_SRC-1:0] en_ff;
    logic [NUM_SRC-1:0] ff_en_ff;
    logic [NUM_SRC-1:0] edge_ff;
    logic [NUM_SRC-1:0] prev_ff;
    logic gmask_ff;
    logic prot_ff;

    logic wr_acc;
    logic rd_acc;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;

    logic [SRC_W-1:0] reg_idx;
    assign reg_idx = paddr[SRC_W+1:2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                mode_ff[i] <= '0;
                svr_ff[i] <= RST_WORD;
            end
            spu_ff <= RST_WORD;
            gmask_ff <= 1'b0;
            prot_ff <= 1'b0;
        end else if (wr_acc) begin
            if ((paddr & BANK_MASK) == SMR_BASE)
                mode_ff[reg_idx] <= vpic_mode_s'({pwdata[TRIG_LSB+1:TRIG_LSB],
                    pwdata[PRIO_LSB+PRIO_W-1:PRIO_LSB]});
            if ((paddr & BANK_MASK) == SVR_BASE)
                svr_ff[reg_idx] <= pwdata;
            if (paddr == SPU_OFF)
                spu_ff <= pwdata;
            if (paddr == DCR_OFF) begin
                prot_ff <= pwdata[0];
                gmask_ff <= pwdata[DCR_GMSK_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= '0;
            ff_en_ff <= '0;
        end else if (wr_acc) begin
            if (paddr == IECR_OFF)
                en_ff <= en_ff | pwdata;
            if (paddr == IDCR_OFF)
                en_ff <= en_ff & ~pwdata;
            if (paddr == FFER_OFF)
                ff_en_ff <= ff_en_ff | pwdata;
            if (paddr == FFDR_OFF)
                ff_en_ff <= ff_en_ff & ~pwdata;
        end
    end

    // ------------------------------------------------------------
    // Input stage: polarity and edge memorisation
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] src_pol;
    logic [NUM_SRC-1:0] src_is_edge;
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            src_is_edge[i] = is_edge(mode_ff[i].trigger_type_field);
            // Internal lines ignore polarity; external lines honour it
            if (ext_mask[i])
                src_pol[i] = mode_ff[i].trigger_type_field[1] ? src_raw[i] : !src_raw[i];
            else
                src_pol[i] = src_raw[i];
        end
    end

    logic [SRC_W-1:0] cur_num_ff;
    logic ivr_rd;
    logic fvr_rd;
    logic take_ok;
    logic [SRC_W-1:0] win_num;
    assign ivr_rd = rd_acc && paddr == IVR_OFF;
    assign fvr_rd = rd_acc && paddr == FVR_OFF;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= src_pol;
        end
    end

    // Hardware set beats every clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_ff <= '0;
        end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (!src_is_edge[i]) begin
                    edge_ff[i] <= 1'b0;
                end else if (src_pol[i] && !prev_ff[i]) begin
                    edge_ff[i] <= 1'b1;
                end else if (wr_acc && paddr == ISCR_OFF && pwdata[i]) begin
                    edge_ff[i] <= 1'b1;
                end else if (wr_acc && paddr == ICCR_OFF && pwdata[i]) begin
                    edge_ff[i] <= 1'b0;
                end else if (ivr_rd && take_ok && win_num == src_idx(i)
                             && !ff_en_ff[i] && i != 0) begin
                    edge_ff[i] <= 1'b0;
                end else if (fvr_rd && i == 0) begin
                    edge_ff[i] <= 1'b0;
                end
            end
        end
    end

    logic [NUM_SRC-1:0] active;
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            active[i] = src_is_edge[i] ? edge_ff[i] : src_pol[i];
        end
    end

    // ------------------------------------------------------------
    // Priority controller and nesting stack
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] normal_cand;
    logic [NUM_SRC-1:0] fast_cand;
    assign normal_cand = active & en_ff & ~ff_en_ff & ~NUM_SRC'(1);
    assign fast_cand = active & en_ff & (ff_en_ff | NUM_SRC'(1));

    logic [PRIO_W-1:0] win_lvl;
    logic win_valid;
    always_comb begin
        win_valid = 1'b0;
        win_lvl = '0;
        win_num = '0;
        // Scan downward so ties land on the lowest number
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (normal_cand[i] && (!win_valid ||
                mode_ff[i].priority_level_field >= win_lvl)) begin
                win_valid = 1'b1;
                win_lvl = mode_ff[i].priority_level_field;
                win_num = src_idx(i);
            end
        end
    end

    vpic_frame_s stack_ff [STACK_DEPTH];
    logic [3:0] depth_ff;
    logic [PRIO_W-1:0] top_lvl;
    assign top_lvl = stack_ff[depth_ff[2:0] - 3'h1].lvl;
    // Equal or lower priority waits for end of service
    assign take_ok = win_valid && (depth_ff == 4'h0 || win_lvl > top_lvl);

    logic eoi_wr;
    assign eoi_wr = wr_acc && paddr == EOICR_OFF;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_ff <= 4'h0;
            cur_num_ff <= '0;
            for (int i = 0; i < STACK_DEPTH; i++)
                stack_ff[i] <= '0;
        end else if (ivr_rd && take_ok && depth_ff < 4'(STACK_DEPTH)) begin
            stack_ff[depth_ff[2:0]] <= '{num: win_num, lvl: win_lvl};
            depth_ff <= depth_ff + 4'h1;
            cur_num_ff <= win_num;
        end else if (eoi_wr && depth_ff != 4'h0) begin
            depth_ff <= depth_ff - 4'h1;
            cur_num_ff <= (depth_ff > 4'h1) ? stack_ff[depth_ff[2:0] - 3'h2].num : '0;
        end
    end

    // Request drops in the vector read cycle and the cycle after it, then follows take_ok again
    logic irq_hold_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_hold_ff <= 1'b0;
        end else if (ivr_rd) begin
            irq_hold_ff <= 1'b1;
        end else begin
            irq_hold_ff <= 1'b0;
        end
    end

    logic irq_want;
    logic fast_want;
    assign irq_want = take_ok && !irq_hold_ff && !ivr_rd;
    assign fast_want = |fast_cand;

    // ------------------------------------------------------------
    // Processor lines
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            normal_int_request_n <= 1'b1;
            fast_int_request_n <= 1'b1;
            core_wake <= 1'b0;
        end else begin
            normal_int_request_n <= !(irq_want && !gmask_ff);
            fast_int_request_n <= !(fast_want && !gmask_ff);
            core_wake <= irq_want || fast_want;
        end
    end

    // ------------------------------------------------------------
    // APB read path; zero wait states, unmapped reads return zero
    // ------------------------------------------------------------
    logic [31:0] rd_word;
    always_comb begin
        rd_word = RST_WORD;
        if ((paddr & BANK_MASK) == SMR_BASE)
            rd_word = 32'({mode_ff[reg_idx].trigger_type_field, 2'h0,
                mode_ff[reg_idx].priority_level_field});
        else if ((paddr & BANK_MASK) == SVR_BASE)
            rd_word = svr_ff[reg_idx];
        else begin
            case (paddr)
                IVR_OFF: rd_word = take_ok ? svr_ff[win_num] : spu_ff;
                FVR_OFF: rd_word = fast_want ? svr_ff[FAST_SRC] : spu_ff;
                ISR_OFF: rd_word = 32'(cur_num_ff);
                IPR_OFF: rd_word = active;
                IMR_OFF: rd_word = en_ff;
                CISR_OFF: rd_word = {30'h0, !normal_int_request_n,
                    !fast_int_request_n};
                DCR_OFF: rd_word = {30'h0, gmask_ff, prot_ff};
                FFSR_OFF: rd_word = ff_en_ff;
                default: rd_word = RST_WORD;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RST_WORD;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= (psel && !penable && !pwrite) ? rd_word : prdata;
            pready <= psel && !penable;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_fast_line: assert property (@(posedge pclk) disable iff (!presetn)
        (fast_want && !gmask_ff) |=> !fast_int_request_n)
        else $error("fast request not asserted");
    a_gmask_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        gmask_ff |=> normal_int_request_n && fast_int_request_n)
        else $error("request under general mask");
    a_wake_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (!normal_int_request_n || !fast_int_request_n) |-> core_wake)
        else $error("request without wake");
    a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        en_ff == '0 |=> normal_int_request_n)
        else $error("disabled source raised request");
    a_push_depth: assert property (@(posedge pclk) disable iff (!presetn)
        (ivr_rd && take_ok && depth_ff < 4'h8) |=> depth_ff == $past(depth_ff) + 4'h1)
        else $error("stack not pushed");
    a_pop_depth: assert property (@(posedge pclk) disable iff (!presetn)
        (eoi_wr && !ivr_rd && depth_ff != 4'h0) |=> depth_ff == $past(depth_ff) - 4'h1)
        else $error("stack not popped");
    a_level_no_latch: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> ((edge_ff & ~$past(src_is_edge)) == '0))
        else $error("level source latched");
    a_ivr_drop: assert property (@(posedge pclk) disable iff (!presetn)
        ivr_rd |=> ##1 normal_int_request_n)
        else $error("request held after vector read");
    a_mask_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == IMR_OFF) |=> prdata == $past(en_ff))
        else $error("mask readback wrong");
    c_nest: cover property (@(posedge pclk) depth_ff == 4'h2);
    c_fast: cover property (@(posedge pclk) !fast_int_request_n);
    c_gmask_wake: cover property (@(posedge pclk) gmask_ff && core_wake);
endmodule // vpic_ctrl
`default_nettype wire

// [bench/vpic_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
module vpic_far_end (
    input wire logic pclk,
    input wire logic normal_int_request_n,
    input wire logic fast_int_request_n,
    input wire logic core_wake,
    output logic [31:0] periph_int,
    output logic fast_int_pin,
    output logic [1:0] ext_int_pins,
    output logic cpu_awake
);
    initial begin
        periph_int = 32'h0;
        fast_int_pin = 1'b0;
        ext_int_pins = 2'h0;
    end
    // Unused lanes carry the inverse, so a leak would show as a false event
    task automatic drive(input logic [31:0] r);
        @(posedge pclk);
        periph_int <= {~r[31:30], r[29:1], ~r[0]};
        fast_int_pin <= r[0];
        ext_int_pins <= r[31:30];
    endtask
    // Idle core resumes on either line or on the wake-only path
    always_ff @(posedge pclk) begin
        cpu_awake <= !normal_int_request_n || !fast_int_request_n || core_wake;
    end
endmodule // vpic_far_end
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import vpic_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, periph, q;
    logic pready, pslverr, normal_n, fast_n, core_wake, cpu_awake, fast_pin;
    logic [1:0] ext_pins;
    int error_cnt = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h5A1451C2;
    // ----------------------------------------
    // Reference model state
    // ----------------------------------------
    int prio[32];
    int trig[32];
    logic [31:0] svr[32];
    logic [31:0] msk = '0, lat = '0, raw = '0, ff = '0, spu = '0;
    logic gm = 1'b0;
    int stk[$];

    always #25 pclk = ~pclk;

    vpic_ctrl #(.NUM_EXT(2)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fast_int_pin(fast_pin),
        .periph_int(periph), .ext_int_pins(ext_pins), .normal_int_request_n(normal_n),
        .fast_int_request_n(fast_n), .core_wake(core_wake));
    vpic_far_end u_far (.pclk(pclk), .normal_int_request_n(normal_n),
        .fast_int_request_n(fast_n), .core_wake(core_wake), .periph_int(periph),
        .fast_int_pin(fast_pin), .ext_int_pins(ext_pins), .cpu_awake(cpu_awake));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] edg();
        for (int i = 0; i < 32; i++)
            edg[i] = trig[i][0];
    endfunction
    // Internal lines are active high whatever the polarity bit says
    function automatic logic [31:0] pnd();
        for (int i = 0; i < 32; i++)
            pnd[i] = trig[i][0] ? lat[i] :
                ((trig[i] == 2 || (i > 0 && i < 30)) ? raw[i] : !raw[i]);
    endfunction
    function automatic int pick();
        int b = -1;
        int cl = stk.size() ? prio[stk[$]] : -1;
        logic [31:0] p = pnd() & msk & ~ff;
        for (int i = 1; i < 32; i++)
            if (p[i] && prio[i] > cl && (b < 0 || prio[i] > prio[b]))
                b = i;
        return b;
    endfunction
    function automatic logic fq();
        return |(pnd() & msk & (ff | 32'h1));
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // ----------------------------------------
    // Bus and model tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            error_cnt++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic setraw(input logic [31:0] r);
        for (int i = 0; i < 32; i++)
            if ((trig[i] == 3 && r[i] && !raw[i]) || (trig[i] == 1 && !r[i] && raw[i]))
                lat[i] = 1'b1;
        raw = r;
        u_far.drive(r);
        repeat (5) @(posedge pclk);
    endtask
    task automatic lines();
        int p;
        repeat (2) @(posedge pclk);
        // Look away from the launching edge so the lines have settled
        @(negedge pclk);
        p = pick();
        chk(normal_n, !(p >= 0 && !gm));
        chk(fast_n, !(fq() && !gm));
        chk(core_wake, p >= 0 || fq());
        chk(pslverr, 1'b0);
        rdc(IPR_OFF, pnd());
        rdc(CISR_OFF, 32'({p >= 0 && !gm, fq() && !gm}));
    endtask
    task automatic ivr();
        int p = pick();
        rdc(IVR_OFF, p < 0 ? spu : svr[p]);
        if (p >= 0) begin
            if (trig[p][0])
                lat[p] = 1'b0;
            if (stk.size() < 8)
                stk.push_back(p);
            rdc(ISR_OFF, 32'(p));
        end
    endtask
    task automatic eoi_all();
        while (stk.size() > 0) begin
            wr(EOICR_OFF, 32'h0);
            void'(stk.pop_back());
            lines();
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [31:0] d;
        logic [31:0] r;
        for (int i = 0; i < 32; i++) begin
            prio[i] = 0;
            trig[i] = 0;
            svr[i] = '0;
        end
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        lines();
        rdc(IMR_OFF, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 32; i++) begin
            trig[i] = (i % 2 || i == 0) ? 3 : 2;
            prio[i] = int'(xs() & 32'h7);
            svr[i] = xs();
            wr(SMR_BASE + ADDR_W'(4 * i), 32'(trig[i] << TRIG_LSB | prio[i]));
            rdc(SMR_BASE + ADDR_W'(4 * i), 32'(trig[i] << TRIG_LSB | prio[i]));
            wr(SVR_BASE + ADDR_W'(4 * i), svr[i]);
        end
        spu = xs();
        wr(SPU_OFF, spu);
        d = xs() & xs();
        wr(IECR_OFF, 32'hFFFF_FFFF);
        wr(IDCR_OFF, d);
        msk = ~d;
        rdc(IMR_OFF, msk);
        $display("config test done");
        repeat (6) begin
            setraw(xs());
            d = xs();
            wr(ISCR_OFF, d);
            lat |= d & edg();
            lines();
            d = xs();
            wr(ICCR_OFF, d);
            lat &= ~(d & edg());
            lines();
        end
        $display("edge test done");
        repeat (12) begin
            d = xs();
            if (d[0]) begin
                wr(ISCR_OFF, d);
                lat |= d & edg();
            end
            ivr();
            lines();
        end
        eoi_all();
        $display("service test done");
        wr(IECR_OFF, 32'h9);
        msk |= 32'h9;
        wr(ISCR_OFF, 32'h9);
        lat |= 32'h9;
        wr(FFER_OFF, 32'h8);
        ff[3] = 1'b1;
        rdc(FFSR_OFF, ff);
        lines();
        ivr();
        lines();
        rdc(FVR_OFF, svr[0]);
        lat[0] = 1'b0;
        lines();
        wr(FFDR_OFF, 32'h8);
        ff[3] = 1'b0;
        eoi_all();
        lines();
        $display("fast test done");
        gm = 1'b1;
        wr(DCR_OFF, 32'h1 << DCR_GMSK_BIT);
        lines();
        chk(cpu_awake, pick() >= 0 || fq());
        gm = 1'b0;
        wr(DCR_OFF, 32'h0);
        lines();
        $display("mask test done");
        for (int t = 0; t < 4; t++) begin
            trig[30] = t;
            wr(SMR_BASE + 12'h078, 32'(t << TRIG_LSB | prio[30]));
            wr(ICCR_OFF, 32'h4000_0000);
            lat[30] = 1'b0;
            r = raw;
            r[30] = t < 2;
            setraw(r);
            lines();
            r[30] = !r[30];
            setraw(r);
            lines();
        end
        $display("pin test done");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
